// >>> hdl/llsc_pkg.sv
package llsc_pkg;

   // ---------------------------------------------
   // Register map
   // ---------------------------------------------
   localparam int          ADDR_W      = 4;
   localparam int          DATA_W      = 16;
   localparam int          DI_N        = 5;
   localparam logic [3:0]  OFS_LOCK    = 4'h0;
   localparam logic [3:0]  OFS_SET     = 4'h1;
   localparam logic [3:0]  OFS_COMMIT  = 4'h2;
   localparam logic [3:0]  OFS_STATUS  = 4'h3;
   localparam logic [3:0]  OFS_PROFILE = 4'h4;

   // ---------------------------------------------
   // Source codes (signed, two's complement)
   // ---------------------------------------------
   localparam logic [7:0]  LOCK_NONE   = 8'h00;
   localparam logic [7:0]  LOCK_ON     = 8'h07;
   localparam logic [7:0]  LOCK_FB     = 8'h08;
   localparam logic [7:0]  POS_LO      = 8'h01;
   localparam logic [7:0]  POS_HI      = 8'h05;
   localparam logic [7:0]  NEG_LO      = 8'hFB;
   localparam logic [7:0]  NEG_HI      = 8'hFF;
   localparam logic [7:0]  PAIR_LO     = 8'hF6;
   localparam logic [7:0]  PAIR_HI     = 8'hF9;
   localparam int          FB_LOCK_BIT = 14;

   // ---------------------------------------------
   // Reset values
   // ---------------------------------------------
   localparam logic [7:0]  RST_LOCK    = 8'h00;
   localparam logic [7:0]  RST_SET     = 8'h00;
   localparam logic        RST_NATIVE  = 1'b1;
   localparam logic [1:0]  SET_ONE     = 2'h0;
   localparam logic [1:0]  SET_TWO     = 2'h1;

   typedef enum logic [1:0] {
      CM_IDLE  = 2'b00,
      CM_START = 2'b01,
      CM_WAIT  = 2'b10
   } llsc_commit_type;

   typedef struct packed {
      logic [DI_N-1:0]   s1;
      logic [DI_N-1:0]   s2;
      logic [DI_N-1:0]   s3;
      logic [7:0]        lock_src;
      logic [7:0]        set_src;
      logic              native;
      logic              lock;
      logic              local_mode;
      logic [1:0]        pset;
      logic              pload;
      llsc_commit_type   cstate;
      logic              nv_start;
      logic [DATA_W-1:0] rdata;
   } llsc_state_type;

   typedef struct packed {
      logic              param_change;
      logic              from_panel;
      logic              macro;
   } llsc_change_type;

   // ---------------------------------------------
   // Code decoding
   // ---------------------------------------------
   function automatic logic is_pos(input logic [7:0] c);
      return (c >= POS_LO) && (c <= POS_HI);
   endfunction

   function automatic logic is_neg(input logic [7:0] c);
      return (c >= NEG_LO) && (c <= NEG_HI);
   endfunction

   function automatic logic is_pair(input logic [7:0] c);
      return (c >= PAIR_LO) && (c <= PAIR_HI);
   endfunction

   // Input n for code +n or -n
   function automatic logic pick(input logic [4:0] v,
                                 input logic [7:0] c);
      logic [7:0] m;
      m = c[7] ? 8'(-c) : c;
      return v[3'(m[2:0] - 3'h1)];
   endfunction

   // Inverted pair: low = active; first input is bit 0
   function automatic logic [1:0] pair_set(input logic [7:0] c,
                                           input logic [4:0] v);
      logic [2:0] k;
      k = 3'(PAIR_HI - c);
      return {~v[3'(k + 3'h1)], ~v[k]};
   endfunction

endpackage

// >>> hdl/llsc_top.sv
`timescale 1ns/10ps

// Contract
// - Inverted pair codes -7..-10 select user set
// - Inverted input fall loads set 2, rise 1
// - Lock active refuses entering local mode
// - Code 0 never asserts the lock
// - Codes 1..5: rise sets, fall clears
// - Code 7 holds lock permanently on
// - Code 8 takes fieldbus word bit 14
// - Fieldbus source only under native profile
// - Codes -1..-5: inverted rise clears, fall sets
// - Commit write 1 saves; reads 1 while busy
// - Panel macro change commits; fieldbus change not
module llsc_top
   import llsc_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output      logic [DATA_W-1:0] rdata,
   // Terminals and panel
   input  wire logic [DI_N-1:0]   digital_input,
   input  wire logic              local_remote_key,
   // Fieldbus
   input  wire logic [15:0]       fieldbus_command_word_one,
   // Parameter change report
   input  wire llsc_change_type   change,
   // Nonvolatile memory
   output      logic              nv_start,
   input  wire logic              nv_done,
   // Status
   output      logic              local_lock,
   output      logic              local_mode,
   output      logic [1:0]        param_set,
   output      logic              param_load
);

   llsc_state_type st;
   llsc_state_type next_st;

   logic [DI_N-1:0] rise;
   logic [DI_N-1:0] fall;
   logic            commit_wr;
   logic            auto_commit;

   // ---------------------------------------------
   // Edge detection
   // ---------------------------------------------
   // s1 feeds only s2; edges look at s2 against s3
   assign rise = st.s2 & ~st.s3;
   assign fall = ~st.s2 & st.s3;

   assign commit_wr = wr && (addr == OFS_COMMIT) && wdata[0];
   assign auto_commit = change.param_change
                        && change.from_panel && change.macro;

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      next_st          = st;
      next_st.s1       = digital_input;
      next_st.s2       = st.s1;
      next_st.s3       = st.s2;
      next_st.pload    = 1'b0;
      next_st.nv_start = 1'b0;
      next_st.rdata    = '0;

      // Register writes
      if (wr) begin
         unique case (addr)
            OFS_LOCK:    next_st.lock_src = wdata[7:0];
            OFS_SET:     next_st.set_src  = wdata[7:0];
            OFS_PROFILE: next_st.native   = wdata[0];
            default:     ;
         endcase
      end

      // Register reads
      if (rd) begin
         unique case (addr)
            OFS_LOCK:    next_st.rdata = {8'h00, st.lock_src};
            OFS_SET:     next_st.rdata = {8'h00, st.set_src};
            OFS_COMMIT:  next_st.rdata = {15'h0000, st.cstate != CM_IDLE};
            OFS_STATUS:  next_st.rdata = {12'h000, st.pset,
                                          st.local_mode, st.lock};
            OFS_PROFILE: next_st.rdata = {15'h0000, st.native};
            default:     next_st.rdata = '0;
         endcase
      end

      // Lock source
      if (st.lock_src == LOCK_ON) begin
         next_st.lock = 1'b1;
      end else if (st.lock_src == LOCK_FB) begin
         // Other profiles ignore the fieldbus bit
         next_st.lock = st.native
                        && fieldbus_command_word_one[FB_LOCK_BIT];
      end else if (is_pos(st.lock_src)) begin
         if (pick(rise, st.lock_src)) begin
            next_st.lock = 1'b1;
         end else if (pick(fall, st.lock_src)) begin
            next_st.lock = 1'b0;
         end
      end else if (is_neg(st.lock_src)) begin
         // Inverted falls when raw rises
         if (pick(rise, st.lock_src)) begin
            next_st.lock = 1'b1;
         end else if (pick(fall, st.lock_src)) begin
            next_st.lock = 1'b0;
         end
      end else begin
         // Code 0 and unused codes leave local control free
         next_st.lock = 1'b0;
      end

      // Panel key; leaving local mode is always allowed
      if (local_remote_key) begin
         if (st.local_mode) begin
            next_st.local_mode = 1'b0;
         end else if (!st.lock) begin
            next_st.local_mode = 1'b1;
         end
      end

      // User parameter set
      if (is_neg(st.set_src)) begin
         if (pick(rise, st.set_src)) begin
            next_st.pset = SET_TWO;
         end else if (pick(fall, st.set_src)) begin
            next_st.pset = SET_ONE;
         end
      end else if (is_pair(st.set_src)) begin
         next_st.pset = pair_set(st.set_src, st.s2);
      end
      next_st.pload = (next_st.pset != st.pset);

      // Commit sequencer; requests while busy are dropped
      unique case (st.cstate)
         CM_IDLE: begin
            if (commit_wr || auto_commit) begin
               next_st.cstate = CM_START;
            end
         end
         CM_START: begin
            next_st.nv_start = 1'b1;
            next_st.cstate   = CM_WAIT;
         end
         CM_WAIT: begin
            if (nv_done) begin
               next_st.cstate = CM_IDLE;
            end
         end
         default: next_st.cstate = CM_IDLE;
      endcase
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st            <= '0;
         st.lock_src   <= RST_LOCK;
         st.set_src    <= RST_SET;
         st.native     <= RST_NATIVE;
         st.pset       <= SET_ONE;
         st.cstate     <= CM_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign rdata      = st.rdata;
   assign nv_start   = st.nv_start;
   assign local_lock = st.lock;
   assign local_mode = st.local_mode;
   assign param_set  = st.pset;
   assign param_load = st.pload;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence seq_commit_req;
      st.cstate == CM_IDLE && commit_wr;
   endsequence

   sequence seq_saving;
      !st.nv_start && st.cstate == CM_WAIT;
   endsequence

   chk_pair_select: assert property (
      is_pair(st.set_src) && !wr
      |=> st.pset == ~2'($past(st.s2) >> (PAIR_HI - $past(st.set_src))))
      else $error("pair set selection wrong");

   chk_inv_set_two: assert property (
      is_neg(st.set_src) && pick(rise, st.set_src) && !wr
      |=> st.pset == SET_TWO)
      else $error("inverted input fall did not load set 2");

   chk_key_refused: assert property (
      st.lock && !st.local_mode && local_remote_key
      |=> !st.local_mode)
      else $error("local mode entered while locked");

   chk_none_unlocked: assert property (
      st.lock_src == LOCK_NONE |=> !st.lock)
      else $error("lock asserted with no source");

   chk_edge_sets: assert property (
      is_pos(st.lock_src) && pick(rise, st.lock_src) |=> st.lock)
      else $error("rising edge did not set lock");

   chk_forced_on: assert property (
      st.lock_src == LOCK_ON |=> st.lock)
      else $error("forced lock not held");

   chk_fb_bit: assert property (
      st.lock_src == LOCK_FB && st.native
      |=> st.lock == $past(fieldbus_command_word_one[FB_LOCK_BIT]))
      else $error("lock does not follow fieldbus bit");

   chk_fb_profile: assert property (
      st.lock_src == LOCK_FB && !st.native |=> !st.lock)
      else $error("fieldbus bit acted under foreign profile");

   chk_inv_clears: assert property (
      is_neg(st.lock_src) && pick(fall, st.lock_src) |=> !st.lock)
      else $error("inverted rise did not clear lock");

   chk_commit_seq: assert property (
      seq_commit_req |=> st.cstate == CM_START ##1 st.nv_start
      ##1 seq_saving)
      else $error("commit sequence broken");

   chk_panel_commit: assert property (
      st.cstate == CM_IDLE && !commit_wr && change.param_change
      && change.from_panel && change.macro |-> ##2 st.nv_start)
      else $error("panel macro change not committed");

   chk_bus_no_commit: assert property (
      st.cstate == CM_IDLE && !commit_wr && change.param_change
      && !change.from_panel |-> ##2 !st.nv_start)
      else $error("fieldbus change committed");

   chk_sync_latency: assert property (
      $rose(digital_input[0]) && !st.lock && st.lock_src == POS_LO
      |=> (!st.lock || st.lock_src != POS_LO)
          ##[1:2] (st.lock || st.lock_src != POS_LO))
      else $error("input edge not acted on after sync");

endmodule

// >>> tb/llsc_nv_model.sv
`timescale 1ns/10ps

// ---------------------------------------------
// Nonvolatile memory stand-in
// ---------------------------------------------
// Slow on purpose, so that the busy reading can be seen
module llsc_nv_model #(
   parameter int DELAY = 8
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Save handshake
   input  wire logic nv_start,
   output      logic nv_done
);
   int cnt;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt     <= 0;
         nv_done <= 1'b0;
      end else begin
         nv_done <= (cnt == 1);
         if (nv_start) begin
            cnt <= DELAY;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps

module tb_top;
   import llsc_pkg::*;

   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic              sys_clk, rst, wr, rd, key, nv_start, nv_done;
   logic              local_lock, local_mode, param_load;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [DI_N-1:0]   di;
   logic [15:0]       fb;
   logic [1:0]        param_set;
   llsc_change_type   change;
   int                bad_count, check_count, nv_count, load_count;

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   llsc_top dut (
      .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .digital_input(di), .local_remote_key(key),
      .fieldbus_command_word_one(fb), .change(change), .nv_start(nv_start),
      .nv_done(nv_done), .local_lock(local_lock), .local_mode(local_mode),
      .param_set(param_set), .param_load(param_load)
   );

   llsc_nv_model u_nv (.sys_clk(sys_clk), .rst(rst), .nv_start(nv_start), .nv_done(nv_done));

   always @(posedge sys_clk) begin
      if (nv_start === 1'b1) nv_count++;
   end

   always @(posedge sys_clk) begin
      if (param_load === 1'b1) load_count++;
   end

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr    <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk);
      rd   <= 1'b0;
      #1;
      chk("rdata", e, rdata);
   endtask

   // Three-stage sampling, so allow a margin
   task automatic set_di(input logic [4:0] v);
      @(posedge sys_clk);
      di <= v;
      tick(5);
   endtask

   task automatic press;
      @(posedge sys_clk);
      key <= 1'b1;
      @(posedge sys_clk);
      key <= 1'b0;
      tick(2);
   endtask

   task automatic print_verdict;
      if (bad_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      logic [4:0] b;
      rst = 1'b1; wr = 1'b0; rd = 1'b0; key = 1'b0; addr = '0; wdata = '0;
      di = '0; fb = '0; change = '0; bad_count = 0; check_count = 0; nv_count = 0;
      load_count = 0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      rd_reg(OFS_LOCK, 16'h0000);
      rd_reg(OFS_COMMIT, 16'h0000);
      rd_reg(4'hF, 16'h0000);
      set_di(5'h1F);
      chk("lock", 16'h0000, 16'(local_lock));
      press;
      chk("local_mode", 16'h0001, 16'(local_mode));
      press;
      set_di(5'h00);
      for (int n = 1; n <= 10; n++) begin
         b = 5'(1 << ((n - 1) % 5));
         wr_reg(OFS_LOCK, (n <= 5) ? 16'(n) : 16'(8'(-(n - 5))));
         set_di(~b);
         chk("lock", 16'h0000, 16'(local_lock));
         set_di(5'h1F);
         chk("lock", 16'h0001, 16'(local_lock));
         set_di(~b);
         chk("lock", 16'h0000, 16'(local_lock));
         set_di(5'h00);
      end
      wr_reg(OFS_LOCK, 16'(LOCK_ON));
      tick(3);
      chk("lock", 16'h0001, 16'(local_lock));
      press;
      chk("local_mode", 16'h0000, 16'(local_mode));
      rd_reg(OFS_STATUS, 16'h0001);
      wr_reg(OFS_LOCK, 16'(LOCK_FB));
      @(posedge sys_clk);
      fb <= 16'h4000;
      tick(4);
      chk("lock", 16'h0001, 16'(local_lock));
      @(posedge sys_clk);
      fb <= 16'hBFFF;
      tick(4);
      chk("lock", 16'h0000, 16'(local_lock));
      @(posedge sys_clk);
      fb <= 16'h4000;
      wr_reg(OFS_PROFILE, 16'h0000);
      tick(4);
      chk("lock", 16'h0000, 16'(local_lock));
      wr_reg(OFS_PROFILE, 16'h0001);
      tick(4);
      chk("lock", 16'h0001, 16'(local_lock));
      wr_reg(OFS_LOCK, 16'(LOCK_NONE));
      tick(4);
      chk("lock", 16'h0000, 16'(local_lock));
      for (int n = 1; n <= 5; n++) begin
         wr_reg(OFS_SET, 16'(8'(-n)));
         set_di(5'(1 << (n - 1)));
         chk("param_set", 16'(SET_TWO), 16'(param_set));
         set_di(5'h00);
         chk("param_set", 16'(SET_ONE), 16'(param_set));
      end
      chk("load_count", 16'h000A, 16'(load_count));
      for (int k = 0; k < 4; k++) begin
         wr_reg(OFS_SET, 16'(8'(-(7 + k))));
         for (int v = 0; v < 4; v++) begin
            set_di(5'((v & 1) << k) | 5'(((v >> 1) & 1) << (k + 1)));
            chk("param_set", 16'({~v[1], ~v[0]}), 16'(param_set));
         end
      end
      wr_reg(OFS_COMMIT, 16'h0001);
      tick(2);
      rd_reg(OFS_COMMIT, 16'h0001);
      tick(12);
      rd_reg(OFS_COMMIT, 16'h0000);
      chk("nv_count", 16'h0001, 16'(nv_count));
      @(posedge sys_clk);
      change <= llsc_change_type'(3'b111);
      @(posedge sys_clk);
      change <= '0;
      tick(20);
      chk("nv_count", 16'h0002, 16'(nv_count));
      @(posedge sys_clk);
      change <= llsc_change_type'(3'b101);
      @(posedge sys_clk);
      change <= '0;
      tick(20);
      chk("nv_count", 16'h0002, 16'(nv_count));
      print_verdict;
   end

   // Whole run is well under 2000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      print_verdict;
   end
endmodule
